/* privileged_enclave_op_gate.sv */
// Pre-dispatch check gate of the privileged enclave operation.
`timescale 1ns/1ps

// What this block does
// - Recognise no-prefix 0F 01 CF escape opcode.
// - Leaf from low 32 accumulator bits.
// - Active transaction aborts before all checks.
// - Invalid opcode: no protection, v8086, management.
// - Invalid opcode when version-1 capability clear.
// - Invalid opcode when privilege level above 0.
// - Invalid opcode on lock/osize/rep/vex prefix.
// - Guest leaf exit via per-leaf bitmap.
// - Protection fault zero when lock/enable clear.
// - Protection fault: undefined leaf, then no paging.
// - Protection fault on expand-down data segment outside 64-bit mode.
// - Width 32 or 64 by mode; data segment.
// - Ignore segment, address-size, register-extension prefixes.
// - Dispatch to leaf only when all pass.
// - Bitmap bit number equals leaf index up to leaf 62; higher leaves use bit 63.
module privileged_enclave_op_gate
  import enclave_gate_pkg::*;
#(
  parameter int CNT_W = 16
) (
  // The register bus shares the core clock and reset.
  input  wire logic               ref_clk,          // Core clock.
  input  wire logic               sys_rst,          // Sync reset, high.
  input  wire logic               psel,             // APB select.
  input  wire logic               penable,          // APB enable.
  input  wire logic               pwrite,           // APB write.
  input  wire logic [11:0]        paddr,            // APB address.
  input  wire logic [31:0]        pwdata,           // APB write data.
  output logic      [31:0]        prdata,           // APB read data.
  output logic                    pready,           // APB ready.
  output logic                    pslverr,          // APB error.

  // The decoded instruction and the state that qualifies it come together.
  input  wire logic               instValid,        // Decoded instruction.
  input  wire logic [7:0]         opEscape,         // First opcode byte.
  input  wire logic [7:0]         opGroup,          // Second opcode byte.
  input  wire logic [7:0]         opModrm,          // Third opcode byte.
  input  wire logic [PFX_W-1:0]   prefixBits,       // Prefixes present.
  input  wire logic [63:0]        wideAccumulator,  // Full accumulator.
  input  wire logic               transactionActive, // Transaction open.
  input  wire logic               protectionEnableBit, // Protected mode.
  input  wire logic               virtual8086Flag,  // Virtual-8086 flag.
  input  wire logic               systemManagementMode, // Management mode.
  input  wire logic [31:0]        capabilityWord,   // Capability leaf word.
  input  wire logic [1:0]         currentPrivilegeLevel, // Privilege.
  input  wire logic               guestMode,        // Virtualized guest.
  input  wire logic               leafExitControl,  // Leaf exit enabled.
  input  wire logic [63:0]        leafExitBitmap,   // Per-leaf exit bits.
  input  wire logic               featureControlLock, // Feature lock.
  input  wire logic               enclaveEnableBit, // Enclave enable.
  input  wire logic               pagingEnableBit,  // Paging enabled.
  input  wire logic               longModeActive,   // Long mode active.
  input  wire logic               codeSegLong,      // Code segment long.
  input  wire logic [3:0]         dataSegType,      // Data segment type.

  // The outcome is handed to the leaf flow straight from flip-flops.
  output logic                    resultValid_q,    // Outcome pulse.
  output result_kind_e            resultKind_q,     // Outcome kind.
  output logic [15:0]             errorCode_q,      // Fault error code.
  output logic [LEAF_W-1:0]       leafIndex_q,      // Selected leaf.
  output logic                    wideMode_q,       // 64-bit widths.
  output logic                    useDataSeg_q      // Linear via data seg.
);

  gate_regs_if #(.CNT_W(CNT_W)) regsBus ();

  gate_apb_regs #(.CNT_W(CNT_W)) regFile (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .regs    (regsBus)
  );

  // Saturating increment, so a full counter keeps its value.
  function automatic logic [CNT_W-1:0] bump(input logic [CNT_W-1:0] v);
    if (&v) begin
      bump = v;
    end else begin
      bump = v + 1'b1;
    end
  endfunction

  logic [PFX_W-1:0]  livePrefixes;
  logic              isOurOpcode;
  logic              takeInst;
  logic [LEAF_W-1:0] leafSel;
  logic              in64;
  logic              udMode;
  logic              udCap;
  logic              udPriv;
  logic              udPrefix;
  logic              exitHit;
  logic              gpEnable;
  logic              gpLeaf;
  logic              gpPaging;
  logic              gpSegment;
  result_kind_e      kindD;
  logic              hitDispatch;
  logic              hitFault;
  logic              hitExit;
  logic              hitAbort;

  // Dropped prefixes never reach the checks.
  assign livePrefixes = prefixBits & ~PFX_IGNORE_MASK;

  // Opcode match; explicit operands do not exist for this form.
  assign isOurOpcode = opEscape == OP_ESCAPE &&
                       opGroup  == OP_GROUP &&
                       opModrm  == OP_LEAF;

  assign takeInst = instValid && isOurOpcode;

  // Upper accumulator half never takes part in leaf selection.
  assign leafSel = wideAccumulator[LEAF_W-1:0];

  assign in64 = longModeActive && codeSegLong;

  assign udMode = !protectionEnableBit || virtual8086Flag ||
                  systemManagementMode;

  assign udCap = !capabilityWord[CAP_V1_BIT];

  assign udPriv = currentPrivilegeLevel > PRIV_TOP;

  assign udPrefix = |(livePrefixes & PFX_FAULT_MASK);

  // Leaves above LEAF_LAST_OWN (62) all share the top bitmap bit.
  always_comb begin
    exitHit = 1'b0;
    if (guestMode && leafExitControl) begin
      if (leafSel <= LEAF_LAST_OWN) begin
        exitHit = leafExitBitmap[leafSel[5:0]];
      end else begin
        exitHit = leafExitBitmap[BITMAP_SHARED];
      end
    end
  end

  assign gpEnable = !featureControlLock || !enclaveEnableBit;

  // Software sets the leaf limit; a leaf at or above it is undefined.
  assign gpLeaf = leafSel >= regsBus.leafLimit;

  assign gpPaging = !pagingEnableBit;

  assign gpSegment = !in64 && !dataSegType[SEG_CODE_BIT] &&
                     dataSegType[SEG_EXPD_BIT];

  // Checks are walked strictly in order; the first failure decides.
  always_comb begin
    kindD = RES_NONE;
    if (takeInst) begin
      if (transactionActive) begin
        kindD = RES_ABORT;
      end else if (udPrefix) begin
        kindD = RES_UD;
      end else if (udMode) begin
        kindD = RES_UD;
      end else if (udCap) begin
        kindD = RES_UD;
      end else if (udPriv) begin
        kindD = RES_UD;
      end else if (exitHit) begin
        kindD = RES_EXIT;
      end else if (gpEnable) begin
        kindD = RES_GP;
      end else if (gpLeaf) begin
        kindD = RES_GP;
      end else if (gpPaging) begin
        kindD = RES_GP;
      end else if (gpSegment) begin
        kindD = RES_GP;
      end else begin
        kindD = RES_DISPATCH;
      end
    end
  end

  // One decode of the outcome feeds all four counters.
  assign hitDispatch = kindD == RES_DISPATCH;

  assign hitFault = kindD == RES_UD || kindD == RES_GP;

  assign hitExit = kindD == RES_EXIT;

  assign hitAbort = kindD == RES_ABORT;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      resultValid_q <= 1'b0;
    end else begin
      resultValid_q <= takeInst;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      resultKind_q <= RES_NONE;
    end else begin
      resultKind_q <= kindD;
    end
  end

  // The protection fault always carries a zero error code.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      errorCode_q <= GP_ERR_CODE;
    end else if (takeInst) begin
      errorCode_q <= GP_ERR_CODE;
    end
  end

  // Leaf and width are handed on with every outcome for the leaf flow.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      leafIndex_q <= '0;
      wideMode_q  <= 1'b0;
    end else if (takeInst) begin
      leafIndex_q <= leafSel;
      wideMode_q  <= in64;
    end
  end

  // Only a dispatched leaf forms linear addresses from the data segment.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      useDataSeg_q <= 1'b0;
    end else if (takeInst) begin
      useDataSeg_q <= hitDispatch;
    end
  end

  // Software can read back the outcome of the newest instruction.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      regsBus.lastKind <= RES_NONE;
      regsBus.lastWide <= 1'b0;
      regsBus.lastLeaf <= 8'h00;
    end else if (takeInst) begin
      regsBus.lastKind <= kindD;
      regsBus.lastWide <= in64;
      regsBus.lastLeaf <= leafSel[7:0];
    end
  end

  // An outcome in the clearing cycle survives as a count of one.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      regsBus.cntDispatch <= '0;
    end else if (hitDispatch) begin
      regsBus.cntDispatch <= regsBus.clearCounts ? CNT_W'(1) :
                             bump(regsBus.cntDispatch);
    end else if (regsBus.clearCounts) begin
      regsBus.cntDispatch <= '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      regsBus.cntFault <= '0;
    end else if (hitFault) begin
      regsBus.cntFault <= regsBus.clearCounts ? CNT_W'(1) :
                          bump(regsBus.cntFault);
    end else if (regsBus.clearCounts) begin
      regsBus.cntFault <= '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      regsBus.cntExit <= '0;
    end else if (hitExit) begin
      regsBus.cntExit <= regsBus.clearCounts ? CNT_W'(1) :
                         bump(regsBus.cntExit);
    end else if (regsBus.clearCounts) begin
      regsBus.cntExit <= '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      regsBus.cntAbort <= '0;
    end else if (hitAbort) begin
      regsBus.cntAbort <= regsBus.clearCounts ? CNT_W'(1) :
                          bump(regsBus.cntAbort);
    end else if (regsBus.clearCounts) begin
      regsBus.cntAbort <= '0;
    end
  end

endmodule

/* enclave_gate_pkg.sv */
// Constants and types shared by the privileged enclave operation gate.
package enclave_gate_pkg;

  // Opcode bytes of the privileged enclave operation.
  localparam logic [7:0] OP_ESCAPE = 8'h0F;
  localparam logic [7:0] OP_GROUP  = 8'h01;
  localparam logic [7:0] OP_LEAF   = 8'hCF;

  // Prefix vector bit positions.
  localparam int PFX_LOCK   = 0;
  localparam int PFX_OSIZE  = 1;
  localparam int PFX_REP    = 2;
  localparam int PFX_VEX    = 3;
  localparam int PFX_SEG    = 4;
  localparam int PFX_ASIZE  = 5;
  localparam int PFX_REGEXT = 6;
  localparam int PFX_W      = 7;

  // Prefixes that fault, and prefixes that are dropped before any check.
  localparam logic [PFX_W-1:0] PFX_FAULT_MASK  = 7'h0F;
  localparam logic [PFX_W-1:0] PFX_IGNORE_MASK = 7'h70;

  // Capability word bit that advertises version 1 enclave support.
  localparam int CAP_V1_BIT = 0;

  // Leaf select width and the exit bitmap layout.
  localparam int          LEAF_W        = 32;
  localparam logic [31:0] LEAF_LAST_OWN = 32'h0000003E;
  localparam logic [5:0]  BITMAP_SHARED = 6'h3F;

  // Data segment type field: bit 3 clear marks data, bit 2 expand-down.
  localparam int SEG_CODE_BIT = 3;
  localparam int SEG_EXPD_BIT = 2;

  // Most privileged level.
  localparam logic [1:0] PRIV_TOP = 2'h0;

  // Error code pushed with the protection fault.
  localparam logic [15:0] GP_ERR_CODE = 16'h0000;

  // Register map, byte addresses.
  localparam logic [11:0] REG_LEAF_LIMIT = 12'h000;
  localparam logic [11:0] REG_CTRL       = 12'h004;
  localparam logic [11:0] REG_LAST       = 12'h008;
  localparam logic [11:0] REG_CNT_DISP   = 12'h00C;
  localparam logic [11:0] REG_CNT_FAULT  = 12'h010;
  localparam logic [11:0] REG_CNT_EXIT   = 12'h014;
  localparam logic [11:0] REG_CNT_ABORT  = 12'h018;

  // Field positions.
  localparam int CTRL_CLR_BIT   = 0;
  localparam int LAST_KIND_LSB  = 0;
  localparam int LAST_WIDE_BIT  = 4;
  localparam int LAST_LEAF_LSB  = 8;

  // Reset value of the defined-leaf count.
  localparam logic [31:0] LEAF_LIMIT_RST = 32'h00000012;

  typedef enum logic [2:0] {
    RES_NONE,
    RES_ABORT,
    RES_UD,
    RES_EXIT,
    RES_GP,
    RES_DISPATCH
  } result_kind_e;

endpackage

/* gate_regs_if.sv */
// Signals between the gate core and its register file.
`timescale 1ns/1ps
interface gate_regs_if #(parameter int CNT_W = 16);
  import enclave_gate_pkg::*;
  logic [31:0]      leafLimit;
  logic             clearCounts;
  result_kind_e     lastKind;
  logic             lastWide;
  logic [7:0]       lastLeaf;
  logic [CNT_W-1:0] cntDispatch;
  logic [CNT_W-1:0] cntFault;
  logic [CNT_W-1:0] cntExit;
  logic [CNT_W-1:0] cntAbort;

  modport core (
    input  leafLimit, clearCounts,
    output lastKind, lastWide, lastLeaf,
    output cntDispatch, cntFault, cntExit, cntAbort
  );
  modport regs (
    output leafLimit, clearCounts,
    input  lastKind, lastWide, lastLeaf,
    input  cntDispatch, cntFault, cntExit, cntAbort
  );
endinterface

/* gate_apb_regs.sv */
// APB register file of the privileged enclave operation gate.
`timescale 1ns/1ps
module gate_apb_regs
  import enclave_gate_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input  wire logic        ref_clk,  // Core clock.
  input  wire logic        sys_rst,  // Synchronous reset, active high.
  input  wire logic        psel,     // APB select.
  input  wire logic        penable,  // APB access phase.
  input  wire logic        pwrite,   // APB write.
  input  wire logic [11:0] paddr,    // APB byte address.
  input  wire logic [31:0] pwdata,   // APB write data.
  output logic      [31:0] prdata,   // APB read data.
  output logic             pready,   // APB ready.
  output logic             pslverr,  // APB error on unmapped address.
  gate_regs_if.regs        regs      // Core side.
);

  logic setupPhase;
  logic writeTaken;
  logic mapped;
  logic [31:0] readData;

  assign setupPhase = psel && !penable;
  assign writeTaken = psel && penable && pready && pwrite;

  always_comb begin
    mapped   = 1'b1;
    readData = 32'h00000000;
    case (paddr)
      REG_LEAF_LIMIT: readData = regs.leafLimit;
      REG_CTRL:       readData = 32'h00000000;
      REG_LAST: begin
        readData[LAST_KIND_LSB +: 3] = regs.lastKind;
        readData[LAST_WIDE_BIT]      = regs.lastWide;
        readData[LAST_LEAF_LSB +: 8] = regs.lastLeaf;
      end
      REG_CNT_DISP:  readData[CNT_W-1:0] = regs.cntDispatch;
      REG_CNT_FAULT: readData[CNT_W-1:0] = regs.cntFault;
      REG_CNT_EXIT:  readData[CNT_W-1:0] = regs.cntExit;
      REG_CNT_ABORT: readData[CNT_W-1:0] = regs.cntAbort;
      default:       mapped = 1'b0;
    endcase
  end

  // Answer is prepared in the setup cycle so the access phase ends at once.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready  <= setupPhase;
      prdata  <= (setupPhase && !pwrite) ? readData : 32'h00000000;
      pslverr <= setupPhase && !mapped;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      regs.leafLimit <= LEAF_LIMIT_RST;
    end else if (writeTaken && paddr == REG_LEAF_LIMIT) begin
      regs.leafLimit <= pwdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      regs.clearCounts <= 1'b0;
    end else begin
      regs.clearCounts <= writeTaken && paddr == REG_CTRL &&
                          pwdata[CTRL_CLR_BIT];
    end
  end

endmodule

/* gate_asserts.sv */
// Concurrent checks on the ports of the enclave operation gate.
`timescale 1ns/1ps
module gate_asserts
  import enclave_gate_pkg::*;
(
  input wire logic             ref_clk,               // Clock.
  input wire logic             sys_rst,               // Reset.
  input wire logic             instValid,             // Instruction.
  input wire logic [7:0]       opEscape,              // Byte one.
  input wire logic [7:0]       opGroup,               // Byte two.
  input wire logic [7:0]       opModrm,               // Byte three.
  input wire logic [PFX_W-1:0] prefixBits,            // Prefixes.
  input wire logic [63:0]      wideAccumulator,       // Accumulator.
  input wire logic             transactionActive,     // Transaction.
  input wire logic             protectionEnableBit,   // Protection.
  input wire logic             virtual8086Flag,       // V8086.
  input wire logic             systemManagementMode,  // Management.
  input wire logic [31:0]      capabilityWord,        // Capability.
  input wire logic [1:0]       currentPrivilegeLevel, // Privilege.
  input wire logic             guestMode,             // Guest.
  input wire logic             leafExitControl,       // Exit control.
  input wire logic [63:0]      leafExitBitmap,        // Exit bitmap.
  input wire logic             resultValid_q,         // Outcome pulse.
  input result_kind_e          resultKind_q,          // Outcome kind.
  input wire logic [15:0]      errorCode_q,           // Error code.
  input wire logic [LEAF_W-1:0] leafIndex_q,          // Leaf.
  input wire logic             useDataSeg_q           // Data segment.
);
  wire logic take = instValid && opEscape == OP_ESCAPE &&
                    opGroup == OP_GROUP && opModrm == OP_LEAF;
  wire logic tk = take && !transactionActive;
  wire logic [31:0] accLow = wideAccumulator[31:0];
  wire logic ud = !protectionEnableBit || virtual8086Flag ||
                  systemManagementMode || !capabilityWord[CAP_V1_BIT] ||
                  currentPrivilegeLevel != PRIV_TOP ||
                  (|(prefixBits & PFX_FAULT_MASK));
  wire logic hit = (accLow < 32'h0000003F) ?
                   leafExitBitmap[accLow[5:0]] : leafExitBitmap[63];
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  property p_take;
    take |=> resultValid_q;
  endproperty
  a_take: assert property (p_take)
    else $error("no outcome pulse");
  property p_quiet;
    !take |=> !resultValid_q;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("outcome pulse without instruction");
  property p_leaf;
    take |=> leafIndex_q == $past(accLow);
  endproperty
  a_leaf: assert property (p_leaf)
    else $error("leaf index wrong");
  property p_abort;
    take && transactionActive |=> resultKind_q == RES_ABORT;
  endproperty
  a_abort: assert property (p_abort)
    else $error("abort missing");
  property p_mode;
    tk && (!protectionEnableBit || virtual8086Flag || systemManagementMode)
      |=> resultKind_q == RES_UD;
  endproperty
  a_mode: assert property (p_mode)
    else $error("mode fault missing");
  property p_cap;
    tk && !capabilityWord[CAP_V1_BIT] |=> resultKind_q == RES_UD;
  endproperty
  a_cap: assert property (p_cap)
    else $error("capability fault");
  property p_priv;
    tk && currentPrivilegeLevel != PRIV_TOP |=> resultKind_q == RES_UD;
  endproperty
  a_priv: assert property (p_priv)
    else $error("privilege fault");
  property p_pfx;
    tk && (|(prefixBits & PFX_FAULT_MASK)) |=> resultKind_q == RES_UD;
  endproperty
  a_pfx: assert property (p_pfx)
    else $error("prefix fault missing");
  property p_exit;
    tk && !ud && guestMode && leafExitControl && hit
      |=> resultKind_q == RES_EXIT;
  endproperty
  a_exit: assert property (p_exit)
    else $error("exit missing");
  property p_err;
    resultValid_q && resultKind_q == RES_GP |-> errorCode_q == GP_ERR_CODE;
  endproperty
  a_err: assert property (p_err)
    else $error("error code not zero");
  property p_seg;
    resultValid_q |-> useDataSeg_q == (resultKind_q == RES_DISPATCH);
  endproperty
  a_seg: assert property (p_seg)
    else $error("data segment flag wrong");
endmodule

bind privileged_enclave_op_gate gate_asserts chk (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .instValid(instValid),
  .opEscape(opEscape), .opGroup(opGroup), .opModrm(opModrm),
  .prefixBits(prefixBits), .wideAccumulator(wideAccumulator),
  .transactionActive(transactionActive),
  .protectionEnableBit(protectionEnableBit),
  .virtual8086Flag(virtual8086Flag),
  .systemManagementMode(systemManagementMode),
  .capabilityWord(capabilityWord),
  .currentPrivilegeLevel(currentPrivilegeLevel), .guestMode(guestMode),
  .leafExitControl(leafExitControl), .leafExitBitmap(leafExitBitmap),
  .resultValid_q(resultValid_q), .resultKind_q(resultKind_q),
  .errorCode_q(errorCode_q), .leafIndex_q(leafIndex_q),
  .useDataSeg_q(useDataSeg_q)
);

/* testbench.sv */
// Self-checking bench for the enclave operation gate.
`timescale 1ns/1ps
module testbench;
  import enclave_gate_pkg::*;
  typedef struct packed {
    logic        v, ta, pe, vm, sm, guest, ctl, lock, en, pg, lma, csl;
    logic [7:0]  md;
    logic [6:0]  pfx;
    logic [1:0]  current_privilege_level;
    logic [3:0]  dst;
    logic [31:0] cap;
    logic [63:0] acc, bmp;
  } stim_s;
  stim_s        want, cur;
  logic         ref_clk = 1'h0, sys_rst = 1'h1, psel = 1'h0, penable = 1'h0;
  logic         pwrite = 1'h0, pready, pslverr, e;
  logic         resultValid_q, wideMode_q, useDataSeg_q;
  logic [11:0]  paddr = 12'h000;
  logic [31:0]  pwdata = 32'h0, prdata, r, leafIndex_q;
  logic [15:0]  errorCode_q;
  result_kind_e resultKind_q;
  int           n_fail = 0, samples_checked = 0, i, cnt[4] = '{default: 0};
  int           lv[6] = '{0, 5, 17, 62, 63, 100};
  always #12.5 ref_clk = ~ref_clk;
  // Stimulus prepared between edges is launched at the next rising edge.
  always @(posedge ref_clk) cur <= want;
  privileged_enclave_op_gate dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .instValid(cur.v),
    .opEscape(OP_ESCAPE), .opGroup(OP_GROUP), .opModrm(cur.md),
    .prefixBits(cur.pfx), .wideAccumulator(cur.acc),
    .transactionActive(cur.ta), .protectionEnableBit(cur.pe),
    .virtual8086Flag(cur.vm), .systemManagementMode(cur.sm),
    .capabilityWord(cur.cap), .currentPrivilegeLevel(cur.current_privilege_level),
    .guestMode(cur.guest), .leafExitControl(cur.ctl),
    .leafExitBitmap(cur.bmp), .featureControlLock(cur.lock),
    .enclaveEnableBit(cur.en), .pagingEnableBit(cur.pg),
    .longModeActive(cur.lma), .codeSegLong(cur.csl), .dataSegType(cur.dst),
    .resultValid_q(resultValid_q), .resultKind_q(resultKind_q),
    .errorCode_q(errorCode_q), .leafIndex_q(leafIndex_q),
    .wideMode_q(wideMode_q), .useDataSeg_q(useDataSeg_q));
  task wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task chkk(input result_kind_e got, input result_kind_e exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t kind %0d expected %0d", $time, got, exp);
    end
  endtask
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'h1;
    @(posedge ref_clk);
    while (pready !== 1'h1 && n < 16) begin
      n++;
      @(posedge ref_clk);
    end
    if (n == 16) begin
      n_fail++;
      $display("[FAIL] %0t bus timeout", $time);
      wrap_up();
    end else begin
      r = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
    end
  endtask
  task rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
    apb(1'h0, a, 32'h0);
    chk(r, x);
    chk({31'h0, e}, {31'h0, xe});
  endtask
  task base;
    want = '{pe: 1'h1, cap: 32'h1, md: OP_LEAF, lock: 1'h1, en: 1'h1,
             pg: 1'h1, lma: 1'h1, csl: 1'h1, default: '0};
  endtask
  // Issues one instruction and checks the outcome one cycle later.
  task go(input result_kind_e k);
    @(negedge ref_clk) want.v = 1'h1;
    @(negedge ref_clk) want.v = 1'h0;
    @(posedge ref_clk) #1;
    chk({31'h0, resultValid_q}, {31'h0, k != RES_NONE});
    chkk(resultKind_q, k);
    if (k != RES_NONE) begin
      chk(leafIndex_q, want.acc[31:0]);
      chk({31'h0, wideMode_q}, {31'h0, want.lma & want.csl});
      chk({31'h0, useDataSeg_q}, {31'h0, k == RES_DISPATCH});
      chk({16'h0, errorCode_q}, {16'h0, GP_ERR_CODE});
    end
    case (k)
      RES_DISPATCH: cnt[0]++;
      RES_UD, RES_GP: cnt[1]++;
      RES_EXIT: cnt[2]++;
      RES_ABORT: cnt[3]++;
      default: ;
    endcase
  endtask
  initial begin
    base();
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'h0;
    rd(REG_LEAF_LIMIT, LEAF_LIMIT_RST, 1'h0);
    rd(12'h01C, 32'h0, 1'h1);
    want.acc = 64'hFFFFFFFF00000003;
    go(RES_DISPATCH);
    want.md = 8'hD7;
    go(RES_NONE);
    base();
    want.ta = 1'h1;
    want.pe = 1'h0;
    go(RES_ABORT);
    base();
    want.pe = 1'h0;
    go(RES_UD);
    base();
    want.vm = 1'h1;
    go(RES_UD);
    base();
    want.sm = 1'h1;
    go(RES_UD);
    base();
    want.cap = 32'hFFFFFFFE;
    go(RES_UD);
    for (i = 1; i < 4; i++) begin
      base();
      want.current_privilege_level = i[1:0];
      want.lock = 1'h0;
      go(RES_UD);
    end
    for (i = 0; i < 7; i++) begin
      base();
      want.pfx = 7'h01 << i;
      go(i < 4 ? RES_UD : RES_DISPATCH);
    end
    for (i = 0; i < 6; i++) begin
      base();
      want.guest = 1'h1;
      want.ctl = 1'h1;
      want.lock = 1'h0;
      want.acc = 64'(lv[i]);
      want.bmp = lv[i] < 63 ? 64'h1 << lv[i] : 64'h8000000000000000;
      go(RES_EXIT);
      want.bmp = ~want.bmp;
      go(RES_GP);
    end
    for (i = 0; i < 2; i++) begin
      base();
      want.guest = i[0];
      want.ctl = !i[0];
      want.bmp = '1;
      go(RES_DISPATCH);
    end
    base();
    want.en = 1'h0;
    go(RES_GP);
    base();
    want.acc = 64'(LEAF_LIMIT_RST);
    go(RES_GP);
    want.acc = 64'(LEAF_LIMIT_RST - 32'h1);
    go(RES_DISPATCH);
    want.pg = 1'h0;
    go(RES_GP);
    base();
    want.lma = 1'h0;
    want.dst = 4'h4;
    go(RES_GP);
    want.lma = 1'h1;
    go(RES_DISPATCH);
    want.csl = 1'h0;
    want.dst = 4'hC;
    go(RES_DISPATCH);
    apb(1'h1, REG_LEAF_LIMIT, 32'h5);
    rd(REG_LEAF_LIMIT, 32'h5, 1'h0);
    base();
    want.acc = 64'h5;
    go(RES_GP);
    want.acc = 64'h4;
    go(RES_DISPATCH);
    rd(REG_LAST, 32'h00000415, 1'h0);
    for (i = 0; i < 4; i++) begin
      rd(REG_CNT_DISP + 12'(4 * i), 32'(cnt[i]), 1'h0);
    end
    apb(1'h1, REG_CTRL, 32'h1);
    repeat (3) @(posedge ref_clk);
    rd(REG_CNT_DISP, 32'h0, 1'h0);
    wrap_up();
  end
endmodule
